// ===== common/bwsc_pkg.sv
// constants for the buffer watermark and statistics counter block
// assumes: one clock, apb register access, 32-bit words
package bwsc_pkg;
   // ---------------------------------------------
   // register map
   // ---------------------------------------------
   localparam int          ADDR_W          = 12;
   localparam logic [11:0] OFS_WATERMARK   = 12'h000;
   localparam logic [11:0] OFS_HOST_INT    = 12'h004;
   localparam logic [11:0] OFS_STATUS      = 12'h008;
   localparam logic [3:0]  CNT_PAGE        = 4'h1;   // counters at 0x100 + 4*index
   localparam int          WM_W            = 8;
   localparam int          WM_INT_LSB      = 0;
   localparam int          WM_PAU_LSB      = 8;
   localparam int          WM_HDR_LSB      = 16;
   localparam int          HI_LOW_BIT      = 0;
   localparam int          ST_PAUSE_BIT    = 0;
   localparam int          ST_HALT_BIT     = 1;
   localparam int          ST_HREQ_BIT     = 2;
   localparam int          ST_FREE_LSB     = 8;
   localparam logic [31:0] WATERMARK_RST   = 32'h0000_0000;
   // ---------------------------------------------
   // counters
   // ---------------------------------------------
   localparam int          CNT_N           = 40;
   localparam int          CNT_W           = 32;
   localparam int          LEN_W           = 16;
   localparam logic [15:0] LEN_MIN         = 16'h0040;  // 64
   localparam logic [15:0] LEN_MAX_STD     = 16'h05ee;  // 1518
   localparam logic [15:0] LEN_MAX_VLAN    = 16'h05f2;  // 1522
   localparam logic [15:0] LEN_FIELD_MAX   = 16'h05dc;  // 1500
   localparam logic [15:0] TYPE_CONTROL    = 16'h8808;
   localparam int          C_TX_OK0        = 0;
   localparam int          C_TX_OK1        = 1;
   localparam int          C_TX_OKN        = 2;
   localparam int          C_TX_EXCOLL     = 3;
   localparam int          C_TX_DEFER      = 4;
   localparam int          C_TX_LATE       = 5;
   localparam int          C_TX_MACERR     = 6;
   localparam int          C_TX_CARRIER    = 7;
   localparam int          C_TX_EXDEFER    = 8;
   localparam int          C_TX_TOTAL      = 9;
   localparam int          C_TX_MCAST      = 10;
   localparam int          C_TX_BCAST      = 11;
   localparam int          C_TX_SQE        = 12;
   localparam int          C_TX_PAUSE      = 13;
   localparam int          C_TX_BYTES      = 14;
   localparam int          C_RX_LE63       = 15;
   localparam int          C_RX_64         = 16;
   localparam int          C_RX_BIN0       = 17;   // 65-127 .. 1024-max, five bins
   localparam int          C_RX_OVER       = 22;
   localparam int          C_RX_CRC        = 23;
   localparam int          C_RX_ALIGN      = 24;
   localparam int          C_RX_FRAG       = 25;
   localparam int          C_RX_JABBER     = 26;
   localparam int          C_RX_MACERR     = 27;
   localparam int          C_RX_DROP       = 28;
   localparam int          C_RX_CLSDROP    = 29;
   localparam int          C_RX_GOOD       = 30;
   localparam int          C_RX_MCAST      = 31;
   localparam int          C_RX_BCAST      = 32;
   localparam int          C_RX_RANGE      = 33;
   localparam int          C_RX_OUTRANGE   = 34;
   localparam int          C_RX_VLAN       = 35;
   localparam int          C_RX_PAUSE      = 36;
   localparam int          C_RX_CTRL       = 37;
   localparam int          C_RX_GBYTES     = 38;
   localparam int          C_RX_EBYTES     = 39;
endpackage

// ===== verilog/bwsc_top.sv
// buffer watermark monitor and mac statistics counters with apb registers
// assumes: event inputs are one-cycle strobes synchronous to clk
//
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/100ps
module bwsc_top
   import bwsc_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic              ce,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // buffer pool and receiver
   input  wire logic [WM_W-1:0]   free_blocks,
   input  wire logic              rx_frame_active,
   output logic                   queue_data_ready,
   output logic                   rx_halt,
   // transmit events
   input  wire logic              tx_done,
   input  wire logic [4:0]        tx_collisions,
   input  wire logic              tx_deferred,
   input  wire logic              tx_multicast,
   input  wire logic              tx_broadcast,
   input  wire logic              tx_pause_frame,
   input  wire logic [LEN_W-1:0]  tx_bytes,
   input  wire logic              tx_excess_coll,
   input  wire logic              tx_late_coll,
   input  wire logic              tx_underrun,
   input  wire logic              tx_halted,
   input  wire logic              tx_lost_carrier,
   input  wire logic              tx_excess_defer,
   input  wire logic              tx_sqe_err,
   // receive events
   input  wire logic              rx_done,
   input  wire logic [LEN_W-1:0]  rx_len,
   input  wire logic [LEN_W-1:0]  rx_len_field,
   input  wire logic [LEN_W-1:0]  rx_data_len,
   input  wire logic              rx_vlan,
   input  wire logic              rx_padded,
   input  wire logic              rx_crc_err,
   input  wire logic              rx_align_err,
   input  wire logic              rx_mac_err,
   input  wire logic              rx_multicast,
   input  wire logic              rx_broadcast,
   input  wire logic              rx_control,
   input  wire logic              rx_pause,
   input  wire logic              rx_dropped,
   input  wire logic              rx_class_drop
);

   // ---------------------------------------------
   // state
   // ---------------------------------------------
   logic [31:0]       watermark_values_reg;
   logic              host_interrupt_reg;     // free-pool-low flag
   logic              halt_req;
   logic [CNT_W-1:0]  cnt [CNT_N];

   // ---------------------------------------------
   // apb decode
   // ---------------------------------------------
   wire               setup_ph  = psel & ~penable;
   wire               wr_take   = psel & penable & pready & pwrite;
   wire               hit_wm    = paddr == OFS_WATERMARK;
   wire               hit_hi    = paddr == OFS_HOST_INT;
   wire               hit_st    = paddr == OFS_STATUS;
   wire [5:0]         cnt_idx   = paddr[7:2];
   wire               hit_cnt   = (paddr[11:8] == CNT_PAGE) && (paddr[1:0] == 2'h0) &&
                                  (cnt_idx < 6'(CNT_N));
   wire               hit_any   = hit_wm | hit_hi | hit_st | hit_cnt;

   // ---------------------------------------------
   // watermark compare
   // ---------------------------------------------
   wire [WM_W-1:0]    thr_int   = watermark_values_reg[WM_INT_LSB +: WM_W];
   wire [WM_W-1:0]    thr_pau   = watermark_values_reg[WM_PAU_LSB +: WM_W];
   wire [WM_W-1:0]    thr_hdr   = watermark_values_reg[WM_HDR_LSB +: WM_W];
   wire               below_int = (thr_int != '0) && (free_blocks < thr_int);
   wire               below_pau = (thr_pau != '0) && (free_blocks < thr_pau);
   wire               below_hdr = (thr_hdr != '0) && (free_blocks < thr_hdr);
   wire               above_hdr = (thr_hdr == '0) || (free_blocks > thr_hdr);

   // ---------------------------------------------
   // read data mux
   // ---------------------------------------------
   wire [31:0]        status_word = {16'h0000, free_blocks, 5'h00,
                                     halt_req, rx_halt, queue_data_ready};
   wire [31:0]        rd_data =
      hit_wm  ? watermark_values_reg :
      hit_hi  ? {31'h0, host_interrupt_reg} :
      hit_st  ? status_word :
      hit_cnt ? cnt[cnt_idx] : 32'h0000_0000;

   // ---------------------------------------------
   // transmit event classification
   // ---------------------------------------------
   logic [CNT_N-1:0]  evt;
   assign evt[C_TX_OK0]     = tx_done & (tx_collisions == 5'h00) & ~tx_deferred & ~tx_excess_defer;
   assign evt[C_TX_OK1]     = tx_done & (tx_collisions == 5'h01);
   assign evt[C_TX_OKN]     = tx_done & (tx_collisions >= 5'h02) & (tx_collisions <= 5'h0f);
   assign evt[C_TX_EXCOLL]  = tx_excess_coll;
   assign evt[C_TX_DEFER]   = tx_done & tx_deferred;
   assign evt[C_TX_LATE]    = tx_late_coll;
   assign evt[C_TX_MACERR]  = tx_underrun | tx_halted;
   assign evt[C_TX_CARRIER] = tx_lost_carrier;
   assign evt[C_TX_EXDEFER] = tx_excess_defer;
   assign evt[C_TX_TOTAL]   = tx_done;
   assign evt[C_TX_MCAST]   = tx_done & tx_multicast;
   assign evt[C_TX_BCAST]   = tx_done & tx_broadcast;
   assign evt[C_TX_SQE]     = tx_sqe_err;
   assign evt[C_TX_PAUSE]   = tx_done & tx_pause_frame;
   assign evt[C_TX_BYTES]   = tx_done;

   // ---------------------------------------------
   // receive event classification
   // ---------------------------------------------
   wire [LEN_W-1:0]   len_max   = rx_vlan ? LEN_MAX_VLAN : LEN_MAX_STD;
   wire               rx_fcs    = rx_crc_err | rx_align_err;
   wire               rx_ok     = rx_done & ~rx_fcs & ~rx_mac_err;
   wire               rx_short  = rx_len < LEN_MIN;
   wire               rx_long   = rx_len > len_max;
   wire               rx_frag   = rx_short & rx_fcs;
   wire               rx_jab    = rx_long & rx_fcs;

   assign evt[C_RX_LE63]    = rx_done & rx_short;
   assign evt[C_RX_64]      = rx_done & (rx_len == LEN_MIN);
   assign evt[C_RX_BIN0]    = rx_done & (rx_len > LEN_MIN) & (rx_len <= 16'd127);
   assign evt[C_RX_BIN0+1]  = rx_done & (rx_len >= 16'd128) & (rx_len <= 16'd255);
   assign evt[C_RX_BIN0+2]  = rx_done & (rx_len >= 16'd256) & (rx_len <= 16'd511);
   assign evt[C_RX_BIN0+3]  = rx_done & (rx_len >= 16'd512) & (rx_len <= 16'd1023);
   assign evt[C_RX_BIN0+4]  = rx_done & (rx_len >= 16'd1024) & ~rx_long;
   assign evt[C_RX_OVER]    = rx_done & rx_long;
   assign evt[C_RX_CRC]     = rx_done & rx_crc_err & ~rx_align_err;
   assign evt[C_RX_ALIGN]   = rx_done & rx_align_err;
   assign evt[C_RX_FRAG]    = rx_done & rx_frag;
   assign evt[C_RX_JABBER]  = rx_done & rx_jab;
   assign evt[C_RX_MACERR]  = rx_done & rx_mac_err;
   assign evt[C_RX_DROP]    = rx_dropped;
   assign evt[C_RX_CLSDROP] = rx_class_drop;
   assign evt[C_RX_GOOD]    = rx_ok;
   assign evt[C_RX_MCAST]   = rx_ok & rx_multicast;
   assign evt[C_RX_BCAST]   = rx_ok & rx_broadcast;
   assign evt[C_RX_RANGE]   = rx_done & (rx_len_field <= LEN_FIELD_MAX) &
                              (rx_data_len <= LEN_FIELD_MAX) & ~rx_control &
                              (rx_len_field != rx_data_len) & ~rx_padded & ~rx_fcs;
   assign evt[C_RX_OUTRANGE]= rx_done & (rx_len_field > LEN_FIELD_MAX) &
                              (rx_len_field != TYPE_CONTROL);
   assign evt[C_RX_VLAN]    = rx_ok & rx_vlan;
   assign evt[C_RX_PAUSE]   = rx_ok & rx_pause;
   assign evt[C_RX_CTRL]    = rx_ok & rx_control;
   assign evt[C_RX_GBYTES]  = rx_ok;
   assign evt[C_RX_EBYTES]  = rx_done & ~rx_ok & ~rx_jab & ~rx_frag;

   // ---------------------------------------------
   // counter array
   // ---------------------------------------------
   // amount added per event: byte counters take a length, all others one
   function automatic logic [CNT_W-1:0] bwsc_amount(input int idx);
      if (idx == C_TX_BYTES) begin
         return CNT_W'(tx_bytes);
      end else if (idx == C_RX_GBYTES || idx == C_RX_EBYTES) begin
         return CNT_W'(rx_len);
      end else begin
         return 32'h0000_0001;
      end
   endfunction

   // software write loads the word; an event in the same cycle still adds
   genvar gi;
   generate
      for (gi = 0; gi < CNT_N; gi++) begin : g_cnt
         wire              wr_me    = wr_take & hit_cnt & (cnt_idx == 6'(gi));
         wire [CNT_W-1:0]  base     = wr_me ? pwdata : cnt[gi];
         wire [CNT_W-1:0]  next_cnt = base + (evt[gi] ? bwsc_amount(gi) : 32'h0000_0000);
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               cnt[gi] <= 32'h0000_0000;
            end else if (ce) begin
               cnt[gi] <= next_cnt;
            end
         end
      end
   endgenerate

   // ---------------------------------------------
   // watermark register and flags
   // ---------------------------------------------
   // low flag is sticky; write one clears, a new low condition wins
   wire next_flag = below_int | (host_interrupt_reg & ~(wr_take & hit_hi & pwdata[HI_LOW_BIT]));

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         watermark_values_reg <= WATERMARK_RST;
         host_interrupt_reg   <= 1'b0;
      end else if (ce) begin
         if (wr_take && hit_wm) begin
            watermark_values_reg <= {8'h00, pwdata[23:0]};
         end
         host_interrupt_reg <= next_flag;
      end
   end

   // ---------------------------------------------
   // pause request and receiver halt
   // ---------------------------------------------
   // halt request has hysteresis: set below, cleared only strictly above or when the threshold is zero
   wire next_halt_req = below_hdr | (halt_req & ~above_hdr);
   // the halt only takes hold between frames so the current frame completes
   wire next_rx_halt  = halt_req & (rx_halt | ~rx_frame_active);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         queue_data_ready <= 1'b0;
         halt_req         <= 1'b0;
         rx_halt          <= 1'b0;
      end else if (ce) begin
         queue_data_ready <= below_pau;
         halt_req         <= next_halt_req;
         rx_halt          <= next_rx_halt;
      end
   end

   // ---------------------------------------------
   // apb answer
   // ---------------------------------------------
   // ready and data are prepared in setup, shown in the first access cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else if (ce) begin
         pready  <= setup_ph;
         pslverr <= setup_ph & ~hit_any;
         if (setup_ph && !pwrite) begin
            prdata <= rd_data;
         end
      end
   end

endmodule // bwsc_top

// ===== test/bwsc_top_sva.sv
// checker for bwsc_top: apb answer timing, map decode, watermark outputs
// assumes: bound to bwsc_top, ce held high, word-aligned apb addresses
`timescale 1ns/100ps
module bwsc_top_sva
   import bwsc_pkg::*;
(
   input wire logic            clk,
   input wire logic            rst_n,
   input wire logic            psel,
   input wire logic            penable,
   input wire logic            pwrite,
   input wire logic [11:0]     paddr,
   input wire logic [31:0]     pwdata,
   input wire logic [31:0]     prdata,
   input wire logic            pready,
   input wire logic            pslverr,
   input wire logic [WM_W-1:0] free_blocks,
   input wire logic            rx_frame_active,
   input wire logic            queue_data_ready,
   input wire logic            rx_halt
);
   // ---------------------------------------------
   // shadow of the thresholds, taken from apb writes
   // ---------------------------------------------
   logic [23:0] wm;
   wire         wm_wr    = psel && penable && pready && pwrite && paddr == OFS_WATERMARK;
   wire         below_p  = wm[15:8] != 8'h00 && free_blocks < wm[15:8];
   wire         above_h  = wm[23:16] == 8'h00 || free_blocks > wm[23:16];
   wire         unmapped = !(paddr < 12'h00c || (paddr >= 12'h100 && paddr < 12'h1a0));
   // shadow register follows the design's write edge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         wm <= 24'h000000;
      else if (wm_wr)
         wm <= pwdata[23:0];
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_aligned_setup;
      s_setup ##0 paddr[1:0] == 2'b00;
   endsequence
   a_ready_after_setup: assert property (s_setup |=> pready) else $error("no ready after setup");
   a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready longer than one cycle");
   a_err_decode: assert property (s_aligned_setup |=> pslverr == $past(unmapped))
      else $error("slave error does not match map");
   a_err_read_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   a_rdata_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
      else $error("read data moved outside read setup");
   a_pause_track: assert property (1'b1 |=> queue_data_ready == $past(below_p))
      else $error("pause request does not track threshold");
   a_halt_after_frame: assert property ($rose(rx_halt) |-> !$past(rx_frame_active))
      else $error("halt during a frame");
   a_halt_cause: assert property ($rose(rx_halt) |-> !$past(above_h, 2))
      else $error("halt without low pool");
   a_halt_release: assert property (above_h |-> ##2 !rx_halt)
      else $error("halt not released");
endmodule // bwsc_top_sva

// ===== test/bwsc_host_model.sv
// host processor model: apb master issuing single word transfers
// assumes: bwsc_top answers with pready, bench timeout ends a hang
`timescale 1ns/100ps
module bwsc_host_model (
   input  wire logic        clk,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic      [11:0] paddr,
   output logic      [31:0] pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   // ---------------------------------------------
   // apb transfer
   // ---------------------------------------------
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
   end
   // setup, then access held until pready is sampled high
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule // bwsc_host_model

// ===== test/bwsc_top_tb_top.sv
// bench for bwsc_top: watermark scenarios, counter events, apb map
// assumes: bwsc_host_model as apb master, ce held high
`timescale 1ns/100ps
module bwsc_top_tb_top
   import bwsc_pkg::*;
;
   // ---------------------------------------------
   // stimulus signals and expectations
   // ---------------------------------------------
   localparam logic [31:0] EXP_CNT [40] = '{1, 1, 2, 1, 1, 1, 2, 1, 1, 5, 1, 1, 1, 1, 1500,
      2, 1, 1, 1, 1, 1, 2, 1, 2, 1, 1, 1, 1, 0, 1, 6, 1, 1, 1, 1, 1, 1, 1, 3869, 576};
   logic        clk = 1'b0, rst_n = 1'b0, rx_frame_active = 1'b0, tx_done = 1'b0, rx_done = 1'b0;
   logic        psel, penable, pwrite, pready, pslverr, queue_data_ready, rx_halt, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [7:0]  free_blocks = 8'hff;
   logic [4:0]  tx_coll = 5'h00;
   logic [3:0]  txq = 4'h0;  // deferred, multicast, broadcast, pause
   logic [8:0]  rxq = 9'h000, evt = 9'h000;
   logic [15:0] tx_bytes = 16'h0, rx_len = 16'h0, rx_fld = 16'h0, rx_dlen = 16'h0;
   int          fail_count = 0, n_compared = 0, cyc = 0;
   always #25 clk = ~clk;
   bwsc_host_model u_host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   bwsc_top dut (.clk(clk), .rst_n(rst_n), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .free_blocks(free_blocks), .rx_frame_active(rx_frame_active), .queue_data_ready(queue_data_ready),
      .rx_halt(rx_halt), .tx_done(tx_done), .tx_collisions(tx_coll), .tx_deferred(txq[3]),
      .tx_multicast(txq[2]), .tx_broadcast(txq[1]), .tx_pause_frame(txq[0]), .tx_bytes(tx_bytes),
      .tx_excess_coll(evt[0]), .tx_late_coll(evt[1]), .tx_underrun(evt[2]), .tx_halted(evt[3]),
      .tx_lost_carrier(evt[4]), .tx_excess_defer(evt[5]), .tx_sqe_err(evt[6]), .rx_done(rx_done),
      .rx_len(rx_len), .rx_len_field(rx_fld), .rx_data_len(rx_dlen), .rx_vlan(rxq[8]), .rx_padded(rxq[7]),
      .rx_crc_err(rxq[6]), .rx_align_err(rxq[5]), .rx_mac_err(rxq[4]), .rx_multicast(rxq[3]),
      .rx_broadcast(rxq[2]), .rx_control(rxq[1]), .rx_pause(rxq[0]), .rx_dropped(evt[7]),
      .rx_class_drop(evt[8]));
   // compare, apb wrappers, event drivers
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      u_host.xfer(1'b1, a, d, q, e);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
      u_host.xfer(1'b0, a, 32'h0, q, e);
      chk(q, x, "read data");
      chk({31'h0, e}, {31'h0, xe}, "slave error");
   endtask
   task automatic tx(input logic [4:0] c, input logic [3:0] f, input logic [15:0] n);
      @(posedge clk);
      tx_done <= 1'b1;
      tx_coll <= c;
      txq <= f;
      tx_bytes <= n;
      @(posedge clk);
      tx_done <= 1'b0;
   endtask
   // flag bits: vlan, padded, crc, align, mac, mcast, bcast, control, pause
   task automatic rx(input logic [15:0] l, input logic [15:0] f, input logic [15:0] d, input logic [8:0] b);
      @(posedge clk);
      rx_done <= 1'b1;
      rx_len <= l;
      rx_fld <= f;
      rx_dlen <= d;
      rxq <= b;
      @(posedge clk);
      rx_done <= 1'b0;
      rxq <= 9'h000;
   endtask
   task automatic settle;
      repeat (4) @(posedge clk);
   endtask
   task automatic end_sim;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // cycle ceiling against a hang
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         fail_count++;
         end_sim;
      end
   end
   // main sequence
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      rd(OFS_WATERMARK, WATERMARK_RST, 1'b0);
      rd(OFS_STATUS, 32'h0000ff00, 1'b0);
      rd(12'h00c, 32'h0, 1'b1);
      rd(12'h1a0, 32'h0, 1'b1);
      wr(OFS_WATERMARK, 32'hffffffff);
      rd(OFS_WATERMARK, 32'h00ffffff, 1'b0);
      wr(OFS_WATERMARK, 32'h00302010);
      free_blocks <= 8'h1f;
      rx_frame_active <= 1'b1;
      settle;
      rd(OFS_STATUS, 32'h00001f05, 1'b0);
      rd(OFS_HOST_INT, 32'h0, 1'b0);
      rx_frame_active <= 1'b0;
      settle;
      rd(OFS_STATUS, 32'h00001f07, 1'b0);
      free_blocks <= 8'h0f;
      settle;
      rd(OFS_HOST_INT, 32'h1, 1'b0);
      free_blocks <= 8'h30;
      settle;
      wr(OFS_HOST_INT, 32'h1);
      rd(OFS_HOST_INT, 32'h0, 1'b0);
      rd(OFS_STATUS, 32'h00003006, 1'b0);
      free_blocks <= 8'h31;
      settle;
      rd(OFS_STATUS, 32'h00003100, 1'b0);
      wr(OFS_WATERMARK, 32'h0);
      free_blocks <= 8'h00;
      settle;
      rd(OFS_STATUS, 32'h0, 1'b0);
      rd(OFS_HOST_INT, 32'h0, 1'b0);
      wr(12'h100 + 12'(4 * C_RX_DROP), 32'hffffffff);
      for (int i = 0; i < 9; i++) begin
         @(posedge clk);
         evt <= 9'(1 << i);
         @(posedge clk);
         evt <= 9'h000;
      end
      tx(5'd0, 4'h0, 16'd100);
      tx(5'd0, 4'hc, 16'd200);
      tx(5'd1, 4'h2, 16'd300);
      tx(5'd15, 4'h1, 16'd400);
      tx(5'd2, 4'h0, 16'd500);
      rx(16'd63, TYPE_CONTROL, 16'd63, 9'h000);
      rx(16'd64, TYPE_CONTROL, 16'd64, 9'h040);
      rx(16'd60, TYPE_CONTROL, 16'd60, 9'h020);
      rx(16'd1522, TYPE_CONTROL, 16'd1522, 9'h100);
      rx(16'd1519, TYPE_CONTROL, 16'd1519, 9'h040);
      rx(16'd127, 16'd100, 16'd109, 9'h008);
      rx(16'd128, 16'd1501, 16'd128, 9'h004);
      rx(16'd1518, TYPE_CONTROL, 16'd1518, 9'h003);
      rx(16'd512, TYPE_CONTROL, 16'd512, 9'h010);
      rx(16'd511, 16'd100, 16'd100, 9'h080);
      for (int i = 0; i < CNT_N; i++)
         rd(12'h100 + 12'(4 * i), EXP_CNT[i], 1'b0);
      end_sim;
   end
endmodule // bwsc_top_tb_top
bind bwsc_top bwsc_top_sva u_sva (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .free_blocks(free_blocks), .rx_frame_active(rx_frame_active), .queue_data_ready(queue_data_ready),
   .rx_halt(rx_halt));
